// ### design/nand_flash_mode_ecc_status.sv
// flash mode access engine, per-select ecc and wait pin status
//
// Operation
// R1 - address lines 16/17 drive command, address latches
// R2 - write protect pin handled outside this block
// R3 - word address lsb appears on address bit 0
// R4 - software builds phases from single accesses
// R5 - chip select released between successive accesses
// R6 - bursts use linear incrementing addresses only
// R7 - dma keeps latch address lines low
// R8 - dma element size, indices, ab sync
// R9 - flash mode select computes ecc over 512 bytes
// R10 - software starts ecc before, reads after
// R11 - separate ecc accumulator per chip select
// R12 - reading ecc result clears start bit
// R13 - writing start bit clears ecc result
// R14 - over 512 bytes gives invalid ecc
// R15 - 8-bit: columns p1-p4, rows p8-p2048
// R16 - 16-bit: columns p1-p8, rows p16-p2048
// R17 - software discards unused high row parities
// R18 - status shows raw wait pin level
// R19 - wait pin rising edge sets raw flag
// R20 - wait polarity affects neither status nor flag
// R21 - software may drive chip enable by gpio
// R22 - host port select uses normal strobe mode
// R23 - each select enters flash mode individually
// R24 - select 2 pairs result 1, up to 5/4
// R25 - no extended wait in flash mode
// R26 - every transferred unit folds into parity
`timescale 1ns/1ps
`default_nettype none
module nand_flash_mode_ecc_status #(
    parameter int ADDR_W = 23                       // external address lines
) (
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    input  wire logic                  acc_req,        // start access, taken when ready
    output logic                       acc_ready,      // engine idle
    input  wire logic                  acc_write,      // 1 write, 0 read
    input  wire logic [1:0]            acc_cs,         // 0 = select 2 .. 3 = select 5
    input  wire logic [ADDR_W+1:0]     acc_addr,       // byte offset in select space
    input  wire logic [7:0]            acc_beats,      // burst length, 0 acts as 1
    input  wire logic [15:0]           acc_wdata,      // write data of current beat
    output logic [15:0]                acc_rdata,      // read data of last beat
    output logic                       acc_rvalid,     // read beat done pulse
    output logic                       acc_beat_done,  // any beat done pulse
    input  wire logic [3:0]            flash_mode_bit, // flash mode per select
    input  wire logic [3:0]            bus_16bit,      // device width per select
    input  wire logic [3:0]            ecc_start_wr,   // write 1 to start bit pulse
    output logic [3:0]                 ecc_start_bits, // ecc running per select
    input  wire logic                  ecc_rd_req,     // result read pulse
    input  wire logic [1:0]            ecc_rd_sel,     // result register index
    output logic [31:0]                ecc_rd_data,    // result read data
    input  wire logic [3:0]            ext_wait_pin,   // ready/busy pins
    output logic [3:0]                 flash_pin_status,
    output logic [3:0]                 irq_raw_status, // wait rise flags
    input  wire logic [3:0]            irq_raw_clear,  // write 1 to clear pulse
    output logic [ADDR_W-1:0]          ext_addr_bus,
    output logic [3:0]                 ext_chip_sel_n,
    output logic                       ext_we_n,
    output logic                       ext_oe_n,
    output logic [15:0]                ext_data_out,
    output logic                       ext_data_oe_n,  // low while driving data
    input  wire logic [15:0]           ext_data_in
);
    // -------------------------------------------------------------------------
    // ecc fold: global bit index {unit, bit} selects even or odd half per pair
    // -------------------------------------------------------------------------
    function automatic logic [31:0] ecc_fold(input logic [31:0] acc, input logic [15:0] d,
                                             input logic [8:0] unit, input logic w16);
        logic [31:0] r;
        logic [11:0] g;
        r = acc;
        for (int b = 0; b < nand_flash_pkg::DATA_W; b++) begin
            g = w16 ? {unit[7:0], 4'(b)} : {unit[8:0], 3'(b)};  // see R15 see R16
            if ((w16 || b < 8) && d[b]) begin
                for (int k = 0; k < nand_flash_pkg::ECC_PAIRS; k++) begin
                    if (g[k]) begin
                        r[nand_flash_pkg::ECC_ODD_POS + k] = ~r[nand_flash_pkg::ECC_ODD_POS + k];
                    end else begin
                        r[k] = ~r[k];
                    end
                end
            end
        end
        return r;
    endfunction

    // -------------------------------------------------------------------------
    // access engine state
    // -------------------------------------------------------------------------
    nand_flash_pkg::access_state_e state_reg;  // engine phase
    logic [nand_flash_pkg::TICK_W-1:0] tick_reg; // strobe cycle count
    logic [7:0]        beats_left_reg;         // beats still to run
    logic [1:0]        cs_reg;                 // select of current access
    logic              wr_reg;                 // direction of current access
    logic [ADDR_W-1:0] addr_reg;               // current word address
    logic [15:0]       wdata_reg;              // parked write data

    wire strobe_on  = (state_reg == nand_flash_pkg::ST_STROBE);
    wire strobe_end = strobe_on &&
                      (tick_reg == nand_flash_pkg::TICK_W'(nand_flash_pkg::STROBE_CYC - 1));
    wire take_req   = acc_req && (state_reg == nand_flash_pkg::ST_IDLE);
    wire [15:0] beat_data = wr_reg ? wdata_reg : ext_data_in;   // unit folded into ecc

    // engine sequencing: one strobe per beat, then a gap cycle
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_reg      <= nand_flash_pkg::ST_IDLE;
            tick_reg       <= '0;
            beats_left_reg <= '0;
            cs_reg         <= '0;
            wr_reg         <= 1'b0;
            addr_reg       <= '0;
            wdata_reg      <= '0;
        end else begin
            case (state_reg)
                nand_flash_pkg::ST_IDLE: begin
                    if (take_req) begin
                        // word address lsb lands on line 0, latches follow offset
                        addr_reg       <= acc_addr[ADDR_W+1:nand_flash_pkg::WORD_SHIFT]; // see R1 see R3
                        cs_reg         <= acc_cs;
                        wr_reg         <= acc_write;
                        beats_left_reg <= (acc_beats == 8'h00) ? 8'h01 : acc_beats;
                        if (acc_write) begin
                            wdata_reg <= acc_wdata;
                        end
                        tick_reg  <= '0;
                        state_reg <= nand_flash_pkg::ST_STROBE;
                    end
                end
                nand_flash_pkg::ST_STROBE: begin
                    tick_reg <= tick_reg + 1'b1;
                    if (strobe_end) begin
                        beats_left_reg <= beats_left_reg - 8'h01;
                        state_reg      <= nand_flash_pkg::ST_GAP;  // see R5
                    end
                end
                nand_flash_pkg::ST_GAP: begin
                    if (beats_left_reg != 8'h00) begin
                        addr_reg <= addr_reg + 1'b1;               // see R6
                        if (wr_reg) begin
                            wdata_reg <= acc_wdata;
                        end
                        tick_reg  <= '0;
                        state_reg <= nand_flash_pkg::ST_STROBE;
                    end else begin
                        state_reg <= nand_flash_pkg::ST_IDLE;
                    end
                end
                default: state_reg <= nand_flash_pkg::ST_IDLE;
            endcase
        end
    end

    // read capture and beat pulses
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            acc_rdata     <= '0;
            acc_rvalid    <= 1'b0;
            acc_beat_done <= 1'b0;
        end else begin
            acc_rvalid    <= strobe_end && !wr_reg;
            acc_beat_done <= strobe_end;
            if (strobe_end && !wr_reg) begin
                acc_rdata <= ext_data_in;
            end
        end
    end

    // -------------------------------------------------------------------------
    // external pins: select only during strobe, data parked when not reading
    // -------------------------------------------------------------------------
    assign acc_ready      = (state_reg == nand_flash_pkg::ST_IDLE);
    assign ext_addr_bus   = addr_reg;                                   // see R1
    assign ext_chip_sel_n = strobe_on ? ~(4'h1 << cs_reg) : 4'hf;       // see R5
    assign ext_we_n       = ~(strobe_on && wr_reg);
    assign ext_oe_n       = ~(strobe_on && !wr_reg);
    assign ext_data_out   = wdata_reg;
    assign ext_data_oe_n  = strobe_on && !wr_reg;

    // -------------------------------------------------------------------------
    // per-select ecc: start bit, unit counter, accumulator
    // -------------------------------------------------------------------------
    logic [31:0]                       ecc_result_reg [nand_flash_pkg::NUM_CS];
    logic [nand_flash_pkg::UNIT_W-1:0] unit_cnt_reg   [nand_flash_pkg::NUM_CS];

    genvar i;
    generate
        for (i = 0; i < nand_flash_pkg::NUM_CS; i++) begin : g_ecc
            wire rd_hit = ecc_rd_req && (ecc_rd_sel == 2'(i));          // see R24
            wire fold   = strobe_end && (cs_reg == 2'(i)) &&
                          flash_mode_bit[i] && ecc_start_bits[i];       // see R23 see R9
            // start bit: write 1 sets, result read clears, set wins
            always_ff @(posedge mclk) begin
                if (!reset_n) begin
                    ecc_start_bits[i] <= 1'b0;
                end else if (ecc_start_wr[i]) begin
                    ecc_start_bits[i] <= 1'b1;
                end else if (rd_hit) begin
                    ecc_start_bits[i] <= 1'b0;                          // see R12
                end
            end
            // independent accumulator per select
            always_ff @(posedge mclk) begin
                if (!reset_n) begin
                    ecc_result_reg[i] <= nand_flash_pkg::ECC_RESET;     // see R11
                    unit_cnt_reg[i]   <= '0;
                end else if (ecc_start_wr[i]) begin
                    ecc_result_reg[i] <= nand_flash_pkg::ECC_RESET;     // see R13
                    unit_cnt_reg[i]   <= '0;
                end else if (fold) begin
                    ecc_result_reg[i] <= ecc_fold(ecc_result_reg[i], beat_data,
                                                  unit_cnt_reg[i], bus_16bit[i]); // see R26
                    unit_cnt_reg[i]   <= unit_cnt_reg[i] + 1'b1;
                end
            end
        end
    endgenerate

    // result read port, one cycle latency
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ecc_rd_data <= '0;
        end else if (ecc_rd_req) begin
            ecc_rd_data <= ecc_result_reg[ecc_rd_sel];
        end
    end

    // -------------------------------------------------------------------------
    // wait pins: raw level and rising edge flags, polarity never applied
    // -------------------------------------------------------------------------
    wire [3:0] wait_rise = ext_wait_pin & ~flash_pin_status;            // see R19 see R20

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            // status keeps tracking the pin in reset so no false rise follows release
            flash_pin_status <= ext_wait_pin;                           // see R18
            irq_raw_status   <= 4'h0;
        end else begin
            flash_pin_status <= ext_wait_pin;                           // see R18
            irq_raw_status   <= (irq_raw_status & ~irq_raw_clear) | wait_rise; // see R19
        end
    end

    // -------------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    cs_release_a: assert property (strobe_end |=> ext_chip_sel_n == 4'hf) // see R5
        else $error("chip select not released after access");
    strobe_len_a: assert property ($fell(ext_chip_sel_n[0]) |-> !ext_chip_sel_n[0] [*3])
        else $error("strobe shorter than three cycles");
    addr_map_a: assert property (take_req |=>                           // see R3
        ext_addr_bus == $past(acc_addr[ADDR_W+1:2]))
        else $error("word address not placed on address lines");
    addr_incr_a: assert property (state_reg == nand_flash_pkg::ST_GAP && beats_left_reg != 0
        |=> ext_addr_bus == $past(ext_addr_bus) + 1'b1)                 // see R6
        else $error("burst address not incremented");
    ecc_clear_a: assert property (ecc_start_wr[0] |=>                   // see R13
        ecc_result_reg[0] == 32'h0 && ecc_start_bits[0])
        else $error("start write did not clear result");
    rd_clear_a: assert property (ecc_rd_req && ecc_rd_sel == 2'd1 && !ecc_start_wr[1]
        |=> !ecc_start_bits[1])                                         // see R12
        else $error("result read did not clear start bit");
    ecc_hold_a: assert property (!ecc_start_bits[2] && !ecc_start_wr[2]
        |=> $stable(ecc_result_reg[2]))                                 // see R9
        else $error("ecc changed while not started");
    ecc_count_a: assert property (g_ecc[0].fold && !ecc_start_wr[0]
        |=> unit_cnt_reg[0] == $past(unit_cnt_reg[0]) + 1'b1)           // see R26
        else $error("transferred unit not folded");
    pin_status_a: assert property (##1 flash_pin_status == $past(ext_wait_pin)) // see R18
        else $error("status does not follow wait pin");
    wait_rise_a: assert property ($rose(ext_wait_pin[2]) |=> irq_raw_status[2]) // see R19
        else $error("wait rise flag not set");

    burst_read_c: cover property (take_req && !acc_write && acc_beats == 8'h04);
    ecc_read_c:   cover property (g_ecc[1].fold ##[1:50] (ecc_rd_req && ecc_rd_sel == 2'd1));
    wait_rise_c:  cover property ($rose(ext_wait_pin[0]) ##1 irq_raw_clear[0]);
endmodule
`default_nettype wire

// ### design/nand_flash_pkg.sv
// constants and types shared by the flash mode, ecc and status logic
package nand_flash_pkg;
    // -------------------------------------------------------------------------
    // chip selects and address mapping
    // -------------------------------------------------------------------------
    localparam int NUM_CS      = 4;     // flash capable selects, index 0 is select 2
    localparam int CLE_BIT     = 16;    // external address line wired to command latch
    localparam int ALE_BIT     = 17;    // external address line wired to address latch
    localparam int WORD_SHIFT  = 2;     // byte offset to 32-bit word address
    // -------------------------------------------------------------------------
    // access timing
    // -------------------------------------------------------------------------
    localparam int CLK_NS      = 10;    // mclk period
    localparam int STROBE_NS   = 30;    // least strobe width of one access
    localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_W      = 4;     // strobe tick counter width
    // -------------------------------------------------------------------------
    // ecc layout: even parity k at bit k, odd parity k at bit ECC_ODD_POS+k
    // -------------------------------------------------------------------------
    localparam int ECC_W       = 32;
    localparam int ECC_PAIRS   = 12;    // p1 .. p2048
    localparam int ECC_ODD_POS = 16;
    localparam logic [31:0] ECC_RESET = 32'h0000_0000;
    localparam int UNIT_W      = 9;     // byte or halfword index within 512 bytes
    localparam int DATA_W      = 16;
    // -------------------------------------------------------------------------
    // access engine states, gray along idle -> strobe -> gap
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_STROBE = 2'b01,
        ST_GAP    = 2'b11
    } access_state_e;
endpackage

// ### dv/nand_flash_model.sv
// behavioural flash device on select 2: latches, page buffer, ready/busy pin
`timescale 1ns/1ps
`default_nettype none
module nand_flash_model #(
    parameter int BUSY_CYC = 6                 // busy time after a command write
) (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        cs_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic        cle,
    input  wire logic        ale,
    input  wire logic [15:0] data_out,
    output logic      [15:0] data_in,
    output logic             ready
);
    // no write-protect input: the system holds it inactive
    logic [7:0]  page_reg [16];                // small page buffer
    logic [3:0]  ptr_reg;                      // column pointer
    logic        wr_reg, rd_reg, cle_reg, ale_reg;
    logic [15:0] wdat_reg, last_reg;
    logic [7:0]  busy_reg;
    wire         wr_act = !cs_n && !we_n;
    wire         rd_act = !cs_n && !oe_n;
    // released bus shows the inverse of the last value
    assign data_in = rd_act ? {8'h00, page_reg[ptr_reg]} : ~last_reg;
    assign ready   = (busy_reg == 8'h00);
    // -------------------------------------------------------------------------
    // strobe end commits a command, address or data unit
    // -------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            {wr_reg, rd_reg, cle_reg, ale_reg} <= 4'h0;
            ptr_reg  <= 4'h0;
            busy_reg <= 8'h00;
            wdat_reg <= 16'h0000;
            last_reg <= 16'h0000;
        end else begin
            wr_reg <= wr_act;
            rd_reg <= rd_act;
            if (wr_act) begin
                cle_reg  <= cle;
                ale_reg  <= ale;
                wdat_reg <= data_out;
            end
            if (rd_act) last_reg <= data_in;
            if (busy_reg != 8'h00) busy_reg <= busy_reg - 8'h01;
            if (wr_reg && !wr_act) begin
                if (cle_reg) busy_reg <= 8'(BUSY_CYC);   // ready/busy low, later rises
                else if (ale_reg) ptr_reg <= 4'h0;
                else begin
                    page_reg[ptr_reg] <= wdat_reg[7:0];
                    ptr_reg <= ptr_reg + 4'h1;
                end
            end
            if (rd_reg && !rd_act) ptr_reg <= ptr_reg + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ### dv/tb.sv
// testbench: single accesses, per-select ecc and wait pin flags
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int AW = 23;
    logic mclk = 1'b0, reset_n = 1'b0, acc_req = 1'b0, acc_write = 1'b0, ecc_rd_req = 1'b0;
    logic [1:0] acc_cs = 2'h0, ecc_rd_sel = 2'h0;
    logic [AW+1:0] acc_addr = '0;
    logic [7:0] acc_beats = 8'h00;
    logic [15:0] acc_wdata = 16'h0000, acc_rdata, ext_data_out, ext_data_in;
    logic [3:0] flash_mode_bit = 4'h0, bus_16bit = 4'h0, ecc_start_wr = 4'h0;
    logic [3:0] irq_raw_clear = 4'h0, ecc_start_bits, flash_pin_status, irq_raw_status;
    logic [3:0] ext_chip_sel_n, ext_wait_pin;
    logic [2:0] wait_tb = 3'h0, st_q;
    logic [31:0] ecc_rd_data, v;
    logic [AW-1:0] ext_addr_bus, addr_q [8];
    logic [3:0] sel_q [8];
    logic [15:0] rd_q [8];
    logic acc_ready, acc_rvalid, acc_beat_done, ext_we_n, ext_oe_n, ext_data_oe_n, fl_ready;
    int fail_count = 0, checks = 0;
    assign ext_wait_pin = {wait_tb, fl_ready};
    always #5 mclk = ~mclk;
    nand_flash_mode_ecc_status #(.ADDR_W(AW)) nand_flash_mode_ecc_status_inst (
        .mclk(mclk), .reset_n(reset_n), .acc_req(acc_req), .acc_ready(acc_ready),
        .acc_write(acc_write), .acc_cs(acc_cs), .acc_addr(acc_addr), .acc_beats(acc_beats),
        .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
        .acc_beat_done(acc_beat_done), .flash_mode_bit(flash_mode_bit), .bus_16bit(bus_16bit),
        .ecc_start_wr(ecc_start_wr), .ecc_start_bits(ecc_start_bits), .ecc_rd_req(ecc_rd_req),
        .ecc_rd_sel(ecc_rd_sel), .ecc_rd_data(ecc_rd_data), .ext_wait_pin(ext_wait_pin),
        .flash_pin_status(flash_pin_status), .irq_raw_status(irq_raw_status),
        .irq_raw_clear(irq_raw_clear), .ext_addr_bus(ext_addr_bus),
        .ext_chip_sel_n(ext_chip_sel_n), .ext_we_n(ext_we_n), .ext_oe_n(ext_oe_n),
        .ext_data_out(ext_data_out), .ext_data_oe_n(ext_data_oe_n), .ext_data_in(ext_data_in));
    nand_flash_model nand_flash_model_inst (
        .mclk(mclk), .reset_n(reset_n), .cs_n(ext_chip_sel_n[0]), .we_n(ext_we_n),
        .oe_n(ext_oe_n), .cle(ext_addr_bus[nand_flash_pkg::CLE_BIT]),
        .ale(ext_addr_bus[nand_flash_pkg::ALE_BIT]), .data_out(ext_data_out),
        .data_in(ext_data_in), .ready(fl_ready));
    // -------------------------------------------------------------------------
    // closing report and comparison
    // -------------------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // reference parity: even pair k at bit k, odd pair k at bit 16+k
    function automatic logic [31:0] ecc_calc(input logic [15:0] q[$], input logic w16);
        logic [31:0] e;
        logic [11:0] g;
        e = 32'h0;
        for (int u = 0; u < q.size(); u++)
            for (int b = 0; b < (w16 ? 16 : 8); b++)
                if (q[u][b]) begin
                    g = w16 ? {u[7:0], b[3:0]} : {u[8:0], b[2:0]};
                    for (int k = 0; k < 12; k++)
                        if (g[k]) e[16+k] = ~e[16+k];
                        else e[k] = ~e[k];
                end
        return e;
    endfunction
    // -------------------------------------------------------------------------
    // one single asynchronous access of d.size() beats, strobes captured
    // -------------------------------------------------------------------------
    task automatic do_acc(input logic wr, input logic [1:0] cs, input logic [AW+1:0] ad,
                          input logic [15:0] d[$]);
        int n;
        @(posedge mclk);
        acc_req <= 1'b1;
        acc_write <= wr;
        acc_cs <= cs;
        acc_addr <= ad;
        acc_beats <= 8'(d.size());
        acc_wdata <= d[0];
        @(posedge mclk);
        acc_req <= 1'b0;
        for (int b = 0; b < d.size(); b++) begin
            for (n = 0; n < 8; n++) begin
                #1;
                if (n == 0) begin
                    addr_q[b] = ext_addr_bus;
                    sel_q[b] = ext_chip_sel_n;
                    st_q = {ext_we_n, ext_oe_n, ext_data_oe_n};
                end
                if (acc_beat_done === 1'b1) break;
                @(posedge mclk);
            end
            if (n == 8) begin
                fail_count++;
                report_and_stop();
            end
            rd_q[b] = acc_rdata;
            chk("rvalid", {31'h0, !wr}, {31'h0, acc_rvalid});
            chk("gap select", 32'hf, {28'h0, ext_chip_sel_n});
            if (b + 1 < d.size()) acc_wdata <= d[b + 1];
            @(posedge mclk);
        end
    endtask
    task automatic ecc_start(input logic [3:0] m);
        @(posedge mclk);
        ecc_start_wr <= m;
        @(posedge mclk);
        ecc_start_wr <= 4'h0;
    endtask
    task automatic ecc_read(input logic [1:0] s);
        @(posedge mclk);
        ecc_rd_req <= 1'b1;
        ecc_rd_sel <= s;
        @(posedge mclk);
        ecc_rd_req <= 1'b0;
        #1;
        v = ecc_rd_data;
    endtask
    task automatic pulse_clear(input logic [3:0] m);
        @(posedge mclk);
        irq_raw_clear <= m;
        @(posedge mclk);
        irq_raw_clear <= 4'h0;
        #1;
    endtask
    // -------------------------------------------------------------------------
    // main sequence: software builds every phase from single accesses
    // chip enable comes from the select, no host port, no extended wait
    // -------------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge mclk);
        #1;
        chk("reset ready", 32'h1, {31'h0, acc_ready});
        chk("reset select", 32'hf, {28'h0, ext_chip_sel_n});
        chk("reset flags", 32'h0, {20'h0, ecc_start_bits, irq_raw_status, 3'h0, ext_data_oe_n});
        @(posedge mclk);
        reset_n <= 1'b1;
        flash_mode_bit <= 4'h7;
        bus_16bit <= 4'h2;
        pulse_clear(4'hf);
        chk("flags cleared", 32'h0, {28'h0, irq_raw_status});
        // command phase raises the command latch line
        do_acc(1'b1, 2'd0, 25'h040000, '{16'h0080});
        chk("cle addr", 32'h010000, 32'(addr_q[0]));
        chk("cmd select", 32'he, {28'h0, sel_q[0]});
        chk("write strobes", 32'h2, {29'h0, st_q});
        @(posedge mclk);
        #1;
        chk("busy status", 32'h0, {31'h0, flash_pin_status[0]});
        repeat (10) @(posedge mclk);
        #1;
        chk("ready status", 32'h1, {31'h0, flash_pin_status[0]});
        chk("rise flag", 32'h1, {28'h0, irq_raw_status});
        pulse_clear(4'h1);
        do_acc(1'b1, 2'd0, 25'h080000, '{16'h0000});
        chk("ale addr", 32'h020000, 32'(addr_q[0]));
        // ecc started before the data phase, at most 512 bytes
        // data phase as a dma runs it: unit steps, latch lines kept low
        ecc_start(4'hb);
        #1;
        chk("start bits", 32'hb, {28'h0, ecc_start_bits});
        do_acc(1'b1, 2'd0, 25'h4, '{16'h0001, 16'h00a5, 16'h003c});
        chk("word lsb", 32'h1, 32'(addr_q[0]));
        chk("linear addr", 32'h3, 32'(addr_q[2]));
        do_acc(1'b1, 2'd1, 25'h0, '{16'h1234, 16'h8001});
        chk("cs3 select", 32'hd, {28'h0, sel_q[0]});
        do_acc(1'b1, 2'd3, 25'h0, '{16'h00ff});
        // short ecc: callers drop unused high pairs, the compare keeps all
        ecc_read(2'd0);
        chk("ecc 8bit", ecc_calc('{16'h0001, 16'h00a5, 16'h003c}, 1'b0), v);
        chk("start after read", 32'ha, {28'h0, ecc_start_bits});
        ecc_read(2'd1);
        chk("ecc 16bit", ecc_calc('{16'h1234, 16'h8001}, 1'b1), v);
        ecc_read(2'd3);
        chk("ecc no flash", 32'h0, v);
        chk("start cleared", 32'h0, {28'h0, ecc_start_bits});
        // read data phase folds into a fresh calculation
        do_acc(1'b1, 2'd0, 25'h080000, '{16'h0000});
        ecc_start(4'h1);
        do_acc(1'b0, 2'd0, 25'h0, '{16'h0000, 16'h0000});
        chk("read strobes", 32'h5, {29'h0, st_q});
        chk("read data 0", 32'h01, {24'h0, rd_q[0][7:0]});
        chk("read data 1", 32'ha5, {24'h0, rd_q[1][7:0]});
        ecc_read(2'd0);
        chk("ecc read path", ecc_calc('{16'h0001, 16'h00a5}, 1'b0), v);
        ecc_start(4'h1);
        ecc_read(2'd0);
        chk("ecc restart", 32'h0, v);
        // wait pin of select 4: rise, clear, fall
        @(posedge mclk);
        wait_tb <= 3'h2;
        @(posedge mclk);
        #1;
        chk("pin status", 32'h5, {28'h0, flash_pin_status});
        chk("pin rise", 32'h4, {28'h0, irq_raw_status});
        pulse_clear(4'h4);
        chk("pin cleared", 32'h0, {28'h0, irq_raw_status});
        @(posedge mclk);
        wait_tb <= 3'h0;
        repeat (2) @(posedge mclk);
        #1;
        chk("fall no flag", 32'h01, {24'h0, irq_raw_status, flash_pin_status});
        report_and_stop();
    end
endmodule
`default_nettype wire
